// >>> cop_consts.vh
// Purpose: constants for the channel output and pin configuration block
// Assumes: 8-bit register index, 16-bit register data, mclk at 100 MHz
// Notes:   offsets are register indices of the first channel's copy, except the one shared parallel register
`ifndef COP_CONSTS_VH
`define COP_CONSTS_VH

`define COP_NUM_CH          4
`define COP_ADDR_W          8
`define COP_DATA_W          16
`define COP_CODE_W          13

// register indices
`define COP_IDX_PARALLEL    8'h0D
`define COP_IDX_PIN_CFG     8'h0E
`define COP_IDX_OUT_CFG     8'h12
`define COP_IDX_TARGET      8'h16
`define COP_IDX_CLR_CODE    8'h1A
`define COP_IDX_APPLIED     8'h1E

// reset values
`define COP_RST_16          16'h0000
`define COP_RST_CODE        13'h0000

// pin_output_mode_config fields
`define COP_PIN_SEL_HI      2
`define COP_PIN_SEL_LO      0
`define COP_PIN_LEVEL_BIT   3
`define COP_PIN_W           4
`define COP_SEL_PULLDOWN    3'h0
`define COP_SEL_STATIC      3'h1
`define COP_SEL_PARALLEL    3'h2
`define COP_SEL_COMPARATOR  3'h3
`define COP_SEL_HIZ         3'h4

// analog_output_config fields
`define COP_OUT_W           8
`define COP_SLEW_HI         7
`define COP_SLEW_LO         6
`define COP_STEP_HI         5
`define COP_STEP_LO         4
`define COP_RATE_HI         3
`define COP_RATE_LO         2
`define COP_CLEAR_ENABLE_BIT      1
`define COP_ILIM_BIT        0
`define COP_SLEW_OFF        2'h0
`define COP_SLEW_LINEAR     2'h1
`define COP_SLEW_HART       2'h2

// linear slew step sizes in codes
`define COP_STEP_0          13'h0040
`define COP_STEP_1          13'h0078
`define COP_STEP_2          13'h01F4
`define COP_STEP_3          13'h071C

// slew update rates in Hz and the cycle counts derived from them
`define COP_MCLK_HZ         100000000
`define COP_RATE0_HZ        4000
`define COP_RATE1_HZ        64000
`define COP_RATE2_HZ        150000
`define COP_RATE3_HZ        240000
`define COP_CNT_W           15
// cycles per update: mclk over rate, rounded down, sized to the divider
`define COP_RATE0_CYC       15'h61A8
`define COP_RATE1_CYC       15'h061A
`define COP_RATE2_CYC       15'h029A
`define COP_RATE3_CYC       15'h01A0

`endif

// >>> cop_channel_cfg.v
// Purpose: per-channel pin mode, output configuration and code registers
// Assumes: register port driven by the serial interface decoder on mclk
// Notes:   pin and code outputs are registered; slew ticks come from free dividers
// Operation
// - four copies per family, consecutive, reset zero
// - mode 001 drives static level bit
// - mode 000 gives weak pull-down
// - mode 010 drives shared parallel bit
// - mode 011 drives debounced comparator result
// - modes 100 to 111 float the pin
// - slew select off, linear or HART
// - linear step 64, 120, 500, 1820 codes
// - linear update 4, 64, 150, 240 kHz
// - clear key loads clear code if enabled
// - bit 0 picks 30 or 7.5 mA
// - 13-bit target code, upper bits zero
// - reserved configuration bits read zero
// - applied code readable, shows slew step
// - shared parallel levels, channel A bit 0
`include "cop_consts.vh"
`timescale 1ns/100ps

module cop_channel_cfg #(
   parameter [`COP_CNT_W-1:0] RATE0_CYCLES = `COP_RATE0_CYC
) (
   input  wire                               mclk,
   input  wire                               resetn,
   input  wire [`COP_ADDR_W-1:0]             reg_addr,
   input  wire [`COP_DATA_W-1:0]             reg_wdata,
   input  wire                               reg_wr,
   input  wire                               reg_rd,
   output reg  [`COP_DATA_W-1:0]             reg_rdata,
   input  wire                               dac_clear_key,
   input  wire [`COP_NUM_CH-1:0]             din_debounced,
   output reg  [`COP_NUM_CH-1:0]             channel_output_pin,
   output reg  [`COP_NUM_CH-1:0]             pin_oe_n,
   output reg  [`COP_NUM_CH-1:0]             pin_pulldown,
   output wire [`COP_NUM_CH*`COP_CODE_W-1:0] applied_code,
   output wire [`COP_NUM_CH-1:0]             hart_slew_en,
   output wire [`COP_NUM_CH-1:0]             low_current_limit
);

   localparam [`COP_CNT_W-1:0] RATE1_CYCLES = `COP_RATE1_CYC;
   localparam [`COP_CNT_W-1:0] RATE2_CYCLES = `COP_RATE2_CYC;
   localparam [`COP_CNT_W-1:0] RATE3_CYCLES = `COP_RATE3_CYC;

   reg  [`COP_NUM_CH-1:0]               shared_parallel_levels_r;
   reg  [`COP_CNT_W-1:0]                div_r [0:3];
   reg  [3:0]                           tick_r;
   wire [`COP_NUM_CH*`COP_PIN_W-1:0]    pin_bus;
   wire [`COP_NUM_CH*`COP_OUT_W-1:0]    out_bus;
   wire [`COP_NUM_CH*`COP_CODE_W-1:0]   tgt_bus;
   wire [`COP_NUM_CH*`COP_CODE_W-1:0]   clr_bus;
   reg  [`COP_DATA_W-1:0]               rdata_nxt;
   reg  [`COP_CNT_W-1:0]                rate_len [0:3];
   integer                              k;
   integer                              j;

   // shared parallel level register
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shared_parallel_levels_r <= {`COP_NUM_CH{1'b0}};
      end else if (reg_wr && reg_addr == `COP_IDX_PARALLEL) begin
         shared_parallel_levels_r <= reg_wdata[`COP_NUM_CH-1:0];
      end
   end

   // one free-running divider per update rate, each emitting a tick;
   // they never restart, so the first step after enabling linear slew
   // lands anywhere up to one period later
   always @* begin
      rate_len[0] = RATE0_CYCLES;
      rate_len[1] = RATE1_CYCLES;
      rate_len[2] = RATE2_CYCLES;
      rate_len[3] = RATE3_CYCLES;
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (k = 0; k < 4; k = k + 1) begin
            div_r[k] <= {`COP_CNT_W{1'b0}};
         end
         tick_r <= 4'h0;
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            if (div_r[k] >= rate_len[k] - 1'b1) begin
               div_r[k]  <= {`COP_CNT_W{1'b0}};
               tick_r[k] <= 1'b1;
            end else begin
               div_r[k]  <= div_r[k] + 1'b1;
               tick_r[k] <= 1'b0;
            end
         end
      end
   end

   genvar i;
   generate
      for (i = 0; i < `COP_NUM_CH; i = i + 1) begin : ch
         reg  [`COP_PIN_W-1:0]  pin_cfg_r;
         reg  [`COP_OUT_W-1:0]  out_cfg_r;
         reg  [`COP_CODE_W-1:0] target_r;
         reg  [`COP_CODE_W-1:0] clr_code_r;
         reg  [`COP_CODE_W-1:0] applied_r;
         reg  [`COP_CODE_W-1:0] applied_nxt;
         reg  [`COP_CODE_W-1:0] step;
         reg  [`COP_CODE_W-1:0] gap;
         wire [2:0]             sel = pin_cfg_r[`COP_PIN_SEL_HI:`COP_PIN_SEL_LO];
         wire [1:0]             slew = out_cfg_r[`COP_SLEW_HI:`COP_SLEW_LO];
         wire [1:0]             rsel = out_cfg_r[`COP_RATE_HI:`COP_RATE_LO];
         wire                   clr_hit = dac_clear_key & out_cfg_r[`COP_CLEAR_ENABLE_BIT];
         localparam [31:0]      CH_NUM = i;
         wire [7:0]             idx = CH_NUM[7:0];
         reg                    hart_r;

         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               pin_cfg_r  <= {`COP_PIN_W{1'b0}};
               out_cfg_r  <= {`COP_OUT_W{1'b0}};
               target_r   <= `COP_RST_CODE;
               clr_code_r <= `COP_RST_CODE;
               hart_r     <= 1'b0;
            end else begin
               if (reg_wr && reg_addr == `COP_IDX_PIN_CFG + idx) begin
                  pin_cfg_r <= reg_wdata[`COP_PIN_W-1:0];
               end
               if (reg_wr && reg_addr == `COP_IDX_OUT_CFG + idx) begin
                  out_cfg_r <= reg_wdata[`COP_OUT_W-1:0];
                  hart_r    <= (reg_wdata[`COP_SLEW_HI:`COP_SLEW_LO] == `COP_SLEW_HART);
               end
               if (clr_hit) begin
                  target_r <= clr_code_r;
               end else if (reg_wr && reg_addr == `COP_IDX_TARGET + idx) begin
                  target_r <= reg_wdata[`COP_CODE_W-1:0];
               end
               if (reg_wr && reg_addr == `COP_IDX_CLR_CODE + idx) begin
                  clr_code_r <= reg_wdata[`COP_CODE_W-1:0];
               end
            end
         end

         always @* begin
            case (out_cfg_r[`COP_STEP_HI:`COP_STEP_LO])
               2'h0:    step = `COP_STEP_0;
               2'h1:    step = `COP_STEP_1;
               2'h2:    step = `COP_STEP_2;
               default: step = `COP_STEP_3;
            endcase
            gap = (applied_r > target_r) ? applied_r - target_r : target_r - applied_r;
            applied_nxt = applied_r;
            if (clr_hit) begin
               applied_nxt = clr_code_r;
            end else if (slew != `COP_SLEW_LINEAR) begin
               // off halts any slew at once; HART shaping is left to the analog section
               applied_nxt = target_r;
            end else if (tick_r[rsel] && gap != {`COP_CODE_W{1'b0}}) begin
               if (gap <= step) begin
                  applied_nxt = target_r;
               end else if (applied_r < target_r) begin
                  applied_nxt = applied_r + step;
               end else begin
                  applied_nxt = applied_r - step;
               end
            end
         end

         always @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               applied_r             <= `COP_RST_CODE;
               channel_output_pin[i] <= 1'b0;
               pin_oe_n[i]           <= 1'b1;
               pin_pulldown[i]       <= 1'b1;
            end else begin
               applied_r <= applied_nxt;
               case (sel)
                  `COP_SEL_PULLDOWN: begin
                     channel_output_pin[i] <= 1'b0;
                     pin_oe_n[i]           <= 1'b1;
                     pin_pulldown[i]       <= 1'b1;
                  end
                  `COP_SEL_STATIC: begin
                     channel_output_pin[i] <= pin_cfg_r[`COP_PIN_LEVEL_BIT];
                     pin_oe_n[i]           <= 1'b0;
                     pin_pulldown[i]       <= 1'b0;
                  end
                  `COP_SEL_PARALLEL: begin
                     channel_output_pin[i] <= shared_parallel_levels_r[i];
                     pin_oe_n[i]           <= 1'b0;
                     pin_pulldown[i]       <= 1'b0;
                  end
                  `COP_SEL_COMPARATOR: begin
                     channel_output_pin[i] <= din_debounced[i];
                     pin_oe_n[i]           <= 1'b0;
                     pin_pulldown[i]       <= 1'b0;
                  end
                  default: begin
                     channel_output_pin[i] <= 1'b0;
                     pin_oe_n[i]           <= 1'b1;
                     pin_pulldown[i]       <= 1'b0;
                  end
               endcase
            end
         end

         assign pin_bus[i*`COP_PIN_W +: `COP_PIN_W]     = pin_cfg_r;
         assign out_bus[i*`COP_OUT_W +: `COP_OUT_W]     = out_cfg_r;
         assign tgt_bus[i*`COP_CODE_W +: `COP_CODE_W]   = target_r;
         assign clr_bus[i*`COP_CODE_W +: `COP_CODE_W]   = clr_code_r;
         assign applied_code[i*`COP_CODE_W +: `COP_CODE_W] = applied_r;
         assign hart_slew_en[i]      = hart_r;
         assign low_current_limit[i] = out_cfg_r[`COP_ILIM_BIT];
      end
   endgenerate

   // read mux; unmapped indices read zero
   always @* begin
      rdata_nxt = `COP_RST_16;
      if (reg_addr == `COP_IDX_PARALLEL) begin
         rdata_nxt[`COP_NUM_CH-1:0] = shared_parallel_levels_r;
      end
      for (j = 0; j < `COP_NUM_CH; j = j + 1) begin
         if (reg_addr == `COP_IDX_PIN_CFG + j[7:0]) begin
            rdata_nxt[`COP_PIN_W-1:0] = pin_bus[j*`COP_PIN_W +: `COP_PIN_W];
         end
         if (reg_addr == `COP_IDX_OUT_CFG + j[7:0]) begin
            rdata_nxt[`COP_OUT_W-1:0] = out_bus[j*`COP_OUT_W +: `COP_OUT_W];
         end
         if (reg_addr == `COP_IDX_TARGET + j[7:0]) begin
            rdata_nxt[`COP_CODE_W-1:0] = tgt_bus[j*`COP_CODE_W +: `COP_CODE_W];
         end
         if (reg_addr == `COP_IDX_CLR_CODE + j[7:0]) begin
            rdata_nxt[`COP_CODE_W-1:0] = clr_bus[j*`COP_CODE_W +: `COP_CODE_W];
         end
         if (reg_addr == `COP_IDX_APPLIED + j[7:0]) begin
            rdata_nxt[`COP_CODE_W-1:0] = applied_code[j*`COP_CODE_W +: `COP_CODE_W];
         end
      end
   end

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `COP_RST_16;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

endmodule

// >>> cop_chk.sv
// Purpose: port assertions for the channel configuration block
// Assumes: single mclk domain, resetn asynchronous active low
// Notes:   attached to every instance by bind
`include "cop_consts.vh"
`timescale 1ns/100ps
module cop_chk #(
   parameter [`COP_CNT_W-1:0] RATE0_CYCLES = `COP_RATE0_CYC
) (
   input wire                               mclk,
   input wire                               resetn,
   input wire [`COP_ADDR_W-1:0]             reg_addr,
   input wire [`COP_DATA_W-1:0]             reg_wdata,
   input wire                               reg_wr,
   input wire                               reg_rd,
   input wire [`COP_DATA_W-1:0]             reg_rdata,
   input wire [`COP_NUM_CH-1:0]             channel_output_pin,
   input wire [`COP_NUM_CH-1:0]             pin_oe_n,
   input wire [`COP_NUM_CH-1:0]             pin_pulldown,
   input wire [`COP_NUM_CH*`COP_CODE_W-1:0] applied_code,
   input wire [`COP_NUM_CH-1:0]             hart_slew_en,
   input wire [`COP_NUM_CH-1:0]             low_current_limit
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   reset_zero_a: assert property ($rose(resetn) |-> applied_code == 0 && pin_oe_n == 4'hF)
      else $error("state not cleared by reset");
   pin_rsvd_a: assert property (reg_rd && reg_addr inside {[8'h0E:8'h11]}
      |=> reg_rdata[15:4] == 12'h000) else $error("pin config upper bits not zero");
   out_rsvd_a: assert property (reg_rd && reg_addr inside {[8'h12:8'h15]}
      |=> reg_rdata[15:8] == 8'h00) else $error("output config upper bits not zero");
   code_rsvd_a: assert property (reg_rd && reg_addr inside {[8'h16:8'h19]}
      |=> reg_rdata[15:13] == 3'h0) else $error("target code upper bits not zero");
   unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h0D || reg_addr > 8'h21)
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   static_drive_a: assert property (reg_wr && reg_addr == 8'h0E && reg_wdata[2:0] == 3'h1
      |-> ##2 !pin_oe_n[0] && channel_output_pin[0] == $past(reg_wdata[3], 2))
      else $error("static level not driven");
   float_pin_a: assert property (reg_wr && reg_addr == 8'h0E && reg_wdata[2]
      |-> ##2 pin_oe_n[0] && !pin_pulldown[0]) else $error("pin not floating");
   pull_undriven_a: assert property ((pin_pulldown & ~pin_oe_n) == 4'h0)
      else $error("pull-down while driving");
   hart_sel_a: assert property (reg_wr && reg_addr == 8'h12
      |=> hart_slew_en[0] == ($past(reg_wdata[7:6]) == 2'h2)) else $error("hart enable wrong");
   ilim_sel_a: assert property (reg_wr && reg_addr == 8'h12
      |=> low_current_limit[0] == $past(reg_wdata[0])) else $error("current limit wrong");
endmodule
bind cop_channel_cfg cop_chk #(.RATE0_CYCLES(RATE0_CYCLES)) chk (.mclk(mclk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_output_pin(channel_output_pin),
   .pin_oe_n(pin_oe_n), .pin_pulldown(pin_pulldown), .applied_code(applied_code),
   .hart_slew_en(hart_slew_en), .low_current_limit(low_current_limit));

// >>> cop_host.sv
// Purpose: host side of the register port
// Assumes: strobes change on falling edges only
// Notes:   write data is inverted once released
`timescale 1ns/100ps
module cop_host (
   input  wire        mclk,
   output reg  [7:0]  reg_addr,
   output reg  [15:0] reg_wdata,
   output reg         reg_wr,
   output reg         reg_rd,
   input  wire [15:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(negedge mclk);
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         @(negedge mclk);
         reg_wr = 1'b0;
         reg_wdata = ~d;
      end
   endtask
   task rd(input [7:0] a, output [15:0] d);
      begin
         @(negedge mclk);
         reg_addr = a;
         reg_rd = 1'b1;
         @(negedge mclk);
         reg_rd = 1'b0;
         d = reg_rdata;
      end
   endtask
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for the channel configuration block
// Assumes: host model drives the register port
// Notes:   slowest slew rate shortened to 20 cycles
`include "cop_consts.vh"
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
   localparam R0 = 20;
   reg         mclk;
   reg         resetn;
   reg         key;
   reg  [3:0]  din;
   wire [7:0]  a;
   wire [15:0] wd, rdat;
   wire        wr, rd;
   wire [3:0]  pin, oen, pd, hart, lim;
   wire [51:0] app;
   integer     fail_count, checks, i, c, s, n, t, last, prev;
   reg  [15:0] m [0:33];
   reg  [15:0] d;
   reg  [7:0]  ad;
   reg  [15:0] ex;
   reg         pe;
   int         per [4] = '{R0, 1562, 666, 416};
   int         stp [4] = '{64, 120, 500, 1820};
   cop_channel_cfg #(.RATE0_CYCLES(R0)) uut (.mclk(mclk), .resetn(resetn), .reg_addr(a),
      .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .dac_clear_key(key),
      .din_debounced(din), .channel_output_pin(pin), .pin_oe_n(oen), .pin_pulldown(pd),
      .applied_code(app), .hart_slew_en(hart), .low_current_limit(lim));
   cop_host host (.mclk(mclk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdat));
   function [15:0] msk(input [7:0] x);
      msk = x inside {[8'h0D:8'h11]} ? 16'h000F : x inside {[8'h12:8'h15]} ? 16'h00FF :
         x inside {[8'h16:8'h1D]} ? 16'h1FFF : 16'h0000;
   endfunction
   task pins;
      for (c = 0; c < 4; c++) begin
         d = m[8'h0E + c];
         pe = d[2:0] == 3'h1 ? d[3] : d[2:0] == 3'h2 ? m[13][c] : din[c];
         `CHK("oe_n", (d[2:0] inside {[3'h1:3'h3]}) ? 1'b0 : 1'b1, oen[c])
         `CHK("pulldown", d[2:0] == 3'h0, pd[c])
         if (d[2:0] inside {[3'h1:3'h3]}) `CHK("pin", pe, pin[c])
         `CHK("hart", m[8'h12 + c][7:6] == 2'h2, hart[c])
         `CHK("limit", m[8'h12 + c][0], lim[c])
         `CHK("applied", m[8'h16 + c][12:0], app[13*c +: 13])
      end
   endtask
   task report_and_stop;
      begin
         if (fail_count == 0 && checks > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #400000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      resetn = 1'b0;
      key = 1'b0;
      din = 4'h0;
      fail_count = 0;
      checks = 0;
      for (i = 0; i < 34; i++) m[i] = 16'h0000;
      i = $urandom(35884);
      repeat (4) @(posedge mclk);
      @(negedge mclk) resetn = 1'b1;
      pins;
      for (i = 12; i < 36; i++) begin
         host.rd(i[7:0], d);
         `CHK("reset read", 16'h0000, d)
      end
      for (i = 0; i < 300; i++) begin
         ad = 8'h0C + $urandom % 24;
         d = $urandom;
         // linear slew is checked on its own below
         if (ad inside {[8'h12:8'h15]} && d[7:6] == 2'h1) d[7:6] = 2'h3;
         host.wr(ad, d);
         if (ad inside {[8'h0D:8'h1D]}) m[ad] = d & msk(ad);
         din = $urandom;
         if ($urandom % 8 == 0) begin
            @(negedge mclk) key = 1'b1;
            @(negedge mclk) key = 1'b0;
            for (c = 0; c < 4; c++) if (m[8'h12 + c][1]) m[8'h16 + c] = m[8'h1A + c];
         end
         ad = 8'h0C + $urandom % 24;
         host.rd(ad, d);
         ex = ad > 8'h21 ? 16'h0 : ad > 8'h1D ? m[ad - 8] : m[ad] & msk(ad);
         `CHK("rdata", ex, d)
         pins;
      end
      for (s = 0; s < 4; s++) begin
         host.wr(8'h12, 16'h0000);
         host.wr(8'h16, 16'h0000);
         host.wr(8'h12, 16'h0040 | s[1:0] << 4 | s[1:0] << 2);
         t = 3 * stp[s] + 7;
         host.wr(8'h16, t[15:0]);
         prev = 0;
         n = 0;
         last = 0;
         for (i = 0; i < 5 * per[s] && prev != t; i++) begin
            @(negedge mclk);
            if (app[12:0] !== prev) begin
               `CHK("step", 13'(prev + stp[s] < t ? prev + stp[s] : t), app[12:0])
               if (n > 0) `CHK("interval", per[s], i - last)
               n++;
               last = i;
               prev = app[12:0];
            end
         end
         `CHK("steps", 4, n)
      end
      host.wr(8'h16, 16'h0000);
      host.wr(8'h12, 16'h0000);
      host.rd(8'h1E, d);
      `CHK("halt", 16'h0000, d)
      report_and_stop;
   end
endmodule
